// ---- verilog/list_ptr_regs.vh ----
// Register offsets, field positions, reset values and timing for the list pointer block
`ifndef LIST_PTR_REGS_VH
`define LIST_PTR_REGS_VH
`define OFS_CTRL_HEAD 6'h20
`define OFS_CTRL_CUR 6'h24
`define OFS_BULK_HEAD 6'h28
`define OFS_BULK_CUR 6'h2C
`define OFS_DONE_HEAD 6'h30
`define OFS_LIST_CTRL 6'h00
`define OFS_INT_STATUS 6'h04
`define OFS_INT_MASK 6'h08
`define PTR_RESET 32'h00000000
`define PTR_MASK 32'hFFFFFFF0
`define BIT_CTRL_EN 0
`define BIT_BULK_EN 1
`define BIT_CTRL_FILLED 2
`define BIT_BULK_FILLED 3
`define BIT_WB_STATUS 0
`define BIT_LIST_END 1
`define INT_BITS 2
`define WB_PERIOD_NS 1000
`define CLK_PERIOD_NS 10
`define WB_PERIOD_CYC (`WB_PERIOD_NS / `CLK_PERIOD_NS)
`define WB_LAST_CNT 7'h63
`endif

// ---- verilog/list_walker.v ----
// Walks one endpoint list: advances the current pointer and wraps through the filled flag
`timescale 1ns/1ps
`default_nettype none
module list_walker (
  input wire core_clk,
  input wire rst,
  input wire sw_write,
  input wire [31:0] sw_data,
  input wire served,
  input wire [31:0] next_ptr,
  input wire [31:0] head_ptr,
  input wire filled,
  output reg [31:0] cur_reg,
  output wire at_end,
  output wire clear_filled
);
`include "list_ptr_regs.vh"
  reg [31:0] cur_next;
  assign at_end = (cur_reg == `PTR_RESET);
  // Wrap only happens when the list is exhausted and software flagged new work
  assign clear_filled = served && at_end && filled;
  always @* begin
    cur_next = cur_reg;
    if (sw_write) begin
      cur_next = sw_data & `PTR_MASK;
    end else if (served && !at_end) begin
      cur_next = next_ptr & `PTR_MASK;
    end else if (clear_filled) begin
      cur_next = head_ptr & `PTR_MASK;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= `PTR_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end
endmodule // list_walker
`default_nettype wire

// ---- verilog/done_queue.v ----
// Done-queue head: links completed descriptors and writes the head back
`timescale 1ns/1ps
`default_nettype none
module done_queue (
  input wire core_clk,
  input wire rst,
  input wire td_done,
  input wire [31:0] td_addr,
  input wire wb_tick,
  output reg [31:0] head_reg,
  output reg link_valid_reg,
  output reg [31:0] link_addr_reg,
  output reg [31:0] link_data_reg,
  output reg wb_valid_reg,
  output reg [31:0] wb_data_reg
);
`include "list_ptr_regs.vh"
  reg [31:0] head_next;
  always @* begin
    head_next = head_reg;
    if (wb_tick && head_reg != `PTR_RESET) begin
      head_next = `PTR_RESET;
    end
    // A completion in the writeback cycle starts the next queue
    if (td_done) begin
      head_next = td_addr & `PTR_MASK;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      head_reg <= `PTR_RESET;
      link_valid_reg <= 1'b0;
      link_addr_reg <= `PTR_RESET;
      link_data_reg <= `PTR_RESET;
      wb_valid_reg <= 1'b0;
      wb_data_reg <= `PTR_RESET;
    end else begin
      head_reg <= head_next;
      link_valid_reg <= td_done;
      wb_valid_reg <= wb_tick && head_reg != `PTR_RESET;
      if (td_done) begin
        link_addr_reg <= td_addr & `PTR_MASK;
        link_data_reg <= (wb_tick ? `PTR_RESET : head_reg);
      end
      if (wb_tick && head_reg != `PTR_RESET) begin
        wb_data_reg <= head_reg;
      end
    end
  end
endmodule // done_queue
`default_nettype wire

// ---- verilog/list_pointers.v ----
// List pointer registers of a USB host controller with Avalon-MM slave
// What this block does
// - After serving a control descriptor, current control pointer moves to the next.
// - At control list end, if filled flag set, reload head and clear flag.
// - Current control pointer resets to zero; zero marks end of list.
// - Bulk traversal starts at the bulk head pointer, loaded at initialisation.
// - Bulk endpoints served round-robin; current pointer advances after each.
// - At bulk list end, if bulk filled flag set, reload head and clear flag.
// - Current bulk pointer resets to zero; zero marks end of list.
// - Completed descriptor gets old done head linked, then becomes new head.
// - Done head writeback clears the register and sets writeback status.
`timescale 1ns/1ps
`default_nettype none
module list_pointers (
  input wire core_clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire ctrl_served,
  input wire [31:0] ctrl_next_ptr,
  input wire bulk_served,
  input wire [31:0] bulk_next_ptr,
  input wire init_load,
  input wire [31:0] init_bulk_head,
  input wire td_done,
  input wire [31:0] td_addr,
  output wire [31:0] ctrl_current_desc_ptr,
  output wire [31:0] bulk_current_desc_ptr,
  output wire link_valid,
  output wire [31:0] link_addr,
  output wire [31:0] link_data,
  output wire wb_valid,
  output wire [31:0] wb_data,
  output wire irq
);
`include "list_ptr_regs.vh"
  reg [31:0] ctrl_head_reg;
  reg [31:0] bulk_first_desc_ptr;
  reg [3:0] list_ctrl_reg;
  reg [`INT_BITS-1:0] int_status_reg;
  reg [`INT_BITS-1:0] int_mask_reg;
  reg ack_reg;
  reg [6:0] wb_cnt_reg;
  reg wb_tick;
  wire [31:0] completed_queue_head;
  wire ctrl_clear;
  wire bulk_clear;
  wire ctrl_end;
  wire bulk_end;
  wire [31:0] wmask;
  wire wr;
  wire rd;
  wire ctrl_cur_wr;
  wire bulk_cur_wr;
  wire ctrl_list_enable;
  wire bulk_list_enable;
  wire ctrl_list_filled_flag;
  wire bulk_current_field;
  wire [31:0] rd_data;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // One wait cycle so reads always come from a registered mux
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  // Writes land at the edge where waitrequest is seen low, not at the first one
  assign wr = avs_write && ack_reg;
  assign rd = avs_read && !ack_reg;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lanes
      assign wmask[g*8+7:g*8] = {8{avs_byteenable[g]}};
    end
  endgenerate

  assign ctrl_list_enable = list_ctrl_reg[`BIT_CTRL_EN];
  assign bulk_list_enable = list_ctrl_reg[`BIT_BULK_EN];
  assign ctrl_list_filled_flag = list_ctrl_reg[`BIT_CTRL_FILLED];
  assign bulk_current_field = list_ctrl_reg[`BIT_BULK_FILLED];
  // Writes while the list runs are dropped, so the walker never sees a torn pointer
  assign ctrl_cur_wr = wr && avs_address == `OFS_CTRL_CUR && !ctrl_list_enable;
  assign bulk_cur_wr = wr && avs_address == `OFS_BULK_CUR && !bulk_list_enable;

  list_walker ctrl_walk (
    .core_clk(core_clk),
    .rst(rst),
    .sw_write(ctrl_cur_wr),
    .sw_data(merge(ctrl_current_desc_ptr, avs_writedata, wmask)),
    .served(ctrl_served && ctrl_list_enable),
    .next_ptr(ctrl_next_ptr),
    .head_ptr(ctrl_head_reg),
    .filled(ctrl_list_filled_flag),
    .cur_reg(ctrl_current_desc_ptr),
    .at_end(ctrl_end),
    .clear_filled(ctrl_clear)
  );

  list_walker bulk_walk (
    .core_clk(core_clk),
    .rst(rst),
    .sw_write(bulk_cur_wr),
    .sw_data(merge(bulk_current_desc_ptr, avs_writedata, wmask)),
    .served(bulk_served && bulk_list_enable),
    .next_ptr(bulk_next_ptr),
    .head_ptr(bulk_first_desc_ptr),
    .filled(bulk_current_field),
    .cur_reg(bulk_current_desc_ptr),
    .at_end(bulk_end),
    .clear_filled(bulk_clear)
  );

  done_queue dq (
    .core_clk(core_clk),
    .rst(rst),
    .td_done(td_done),
    .td_addr(td_addr),
    .wb_tick(wb_tick),
    .head_reg(completed_queue_head),
    .link_valid_reg(link_valid),
    .link_addr_reg(link_addr),
    .link_data_reg(link_data),
    .wb_valid_reg(wb_valid),
    .wb_data_reg(wb_data)
  );

  // Writeback happens on a fixed divider tick standing in for the frame boundary
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_cnt_reg <= 7'h00;
      wb_tick <= 1'b0;
    end else if (wb_cnt_reg == `WB_LAST_CNT) begin
      wb_cnt_reg <= 7'h00;
      wb_tick <= 1'b1;
    end else begin
      wb_cnt_reg <= wb_cnt_reg + 7'h01;
      wb_tick <= 1'b0;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_head_reg <= `PTR_RESET;
      bulk_first_desc_ptr <= `PTR_RESET;
      list_ctrl_reg <= 4'h0;
      int_mask_reg <= {`INT_BITS{1'b0}};
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (init_load) begin
        bulk_first_desc_ptr <= init_bulk_head & `PTR_MASK;
      end else if (wr && avs_address == `OFS_BULK_HEAD) begin
        bulk_first_desc_ptr <= merge(bulk_first_desc_ptr, avs_writedata, wmask) & `PTR_MASK;
      end
      if (wr && avs_address == `OFS_CTRL_HEAD) begin
        ctrl_head_reg <= merge(ctrl_head_reg, avs_writedata, wmask) & `PTR_MASK;
      end
      if (wr && avs_address == `OFS_INT_MASK && avs_byteenable[0]) begin
        int_mask_reg <= avs_writedata[`INT_BITS-1:0];
      end
      if (wr && avs_address == `OFS_LIST_CTRL && avs_byteenable[0]) begin
        list_ctrl_reg <= avs_writedata[3:0];
      end
      // Hardware clear of a filled flag wins only if software is not setting it now
      if (ctrl_clear && !(wr && avs_address == `OFS_LIST_CTRL && avs_byteenable[0] &&
          avs_writedata[2])) begin
        list_ctrl_reg[`BIT_CTRL_FILLED] <= 1'b0;
      end
      if (bulk_clear && !(wr && avs_address == `OFS_LIST_CTRL && avs_byteenable[0] &&
          avs_writedata[3])) begin
        list_ctrl_reg[`BIT_BULK_FILLED] <= 1'b0;
      end
    end
  end

  // Status is read-to-clear; a new event in the read cycle survives
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_status_reg <= {`INT_BITS{1'b0}};
    end else begin
      if (rd && avs_address == `OFS_INT_STATUS) begin
        int_status_reg <= {`INT_BITS{1'b0}};
      end
      if (wb_tick && completed_queue_head != `PTR_RESET) begin
        int_status_reg[`BIT_WB_STATUS] <= 1'b1;
      end
      if ((ctrl_served && ctrl_end) || (bulk_served && bulk_end)) begin
        int_status_reg[`BIT_LIST_END] <= 1'b1;
      end
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  assign rd_data =
    (avs_address == `OFS_CTRL_HEAD) ? ctrl_head_reg :
    (avs_address == `OFS_CTRL_CUR) ? ctrl_current_desc_ptr :
    (avs_address == `OFS_BULK_HEAD) ? bulk_first_desc_ptr :
    (avs_address == `OFS_BULK_CUR) ? bulk_current_desc_ptr :
    (avs_address == `OFS_DONE_HEAD) ? completed_queue_head :
    (avs_address == `OFS_LIST_CTRL) ? {28'h0000000, list_ctrl_reg} :
    (avs_address == `OFS_INT_STATUS) ? {30'h00000000, int_status_reg} :
    (avs_address == `OFS_INT_MASK) ? {30'h00000000, int_mask_reg} :
    32'h00000000;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd) begin
      avs_readdata <= rd_data;
    end
  end
endmodule // list_pointers
`default_nettype wire

// ---- test/list_pointers_props.sv ----
// Port checker for the list pointer block
`timescale 1ns/1ps
`default_nettype none
module list_pointers_props (
  input wire core_clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire ctrl_served,
  input wire [31:0] ctrl_next_ptr,
  input wire bulk_served,
  input wire [31:0] bulk_next_ptr,
  input wire td_done,
  input wire [31:0] ctrl_current_desc_ptr,
  input wire [31:0] bulk_current_desc_ptr,
  input wire link_valid,
  input wire wb_valid,
  input wire [31:0] wb_data
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ptr_low_zero_a: assert property (
    ctrl_current_desc_ptr[3:0] == 4'h0 && bulk_current_desc_ptr[3:0] == 4'h0)
    else $error("pointer low bits set");
  rd_low_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address[5] |-> avs_readdata[3:0] == 4'h0)
    else $error("read low bits set");
  ack_second_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer in second cycle");
  ctrl_advance_a: assert property (ctrl_served |=>
    ctrl_current_desc_ptr == ($past(ctrl_next_ptr) & 32'hFFFFFFF0) || $stable(ctrl_current_desc_ptr))
    else $error("control pointer not advanced");
  bulk_advance_a: assert property (bulk_served |=>
    bulk_current_desc_ptr == ($past(bulk_next_ptr) & 32'hFFFFFFF0) || $stable(bulk_current_desc_ptr))
    else $error("bulk pointer not advanced");
  link_pulse_a: assert property (td_done |=> link_valid)
    else $error("no link write");
  wb_nonzero_a: assert property (
    wb_valid |-> wb_data != 32'h0 && wb_data[3:0] == 4'h0)
    else $error("bad writeback value");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  cover property (bulk_served);
  cover property (wb_valid);
  cover property (td_done ##1 td_done);
endmodule // list_pointers_props
bind list_pointers list_pointers_props i_props (.core_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .ctrl_served, .ctrl_next_ptr, .bulk_served,
  .bulk_next_ptr, .td_done, .ctrl_current_desc_ptr, .bulk_current_desc_ptr, .link_valid,
  .wb_valid, .wb_data);
`default_nettype wire

// ---- test/desc_mem.sv ----
// Memory model: descriptor chain, next-field writes and shared done-head slot
`timescale 1ns/1ps
`default_nettype none
module desc_mem (
  input wire core_clk,
  input wire [31:0] ctrl_current_desc_ptr,
  input wire [31:0] bulk_current_desc_ptr,
  output var logic [31:0] ctrl_next_ptr,
  output var logic [31:0] bulk_next_ptr,
  input wire link_valid,
  input wire [31:0] link_addr,
  input wire [31:0] link_data,
  input wire wb_valid,
  input wire [31:0] wb_data,
  output var logic [31:0] hcca_head
);
  logic [31:0] mem [0:15];
  // Chain 0x10, 0x20, 0x30, end; junk low bits show whether the block masks them
  always_comb begin
    ctrl_next_ptr = ctrl_current_desc_ptr < 32'h30 ? ctrl_current_desc_ptr + 32'h1A : 32'h0;
    bulk_next_ptr = bulk_current_desc_ptr < 32'h30 ? bulk_current_desc_ptr + 32'h1A : 32'h0;
  end
  always @(posedge core_clk) begin
    if (link_valid) mem[link_addr[7:4]] <= link_data;
    if (wb_valid) hcca_head <= wb_data;
  end
endmodule // desc_mem
`default_nettype wire

// ---- test/list_pointers_tb.sv ----
// Self-checking bench for the list pointer block
`timescale 1ns/1ps
`default_nettype none
module list_pointers_tb;
  logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0, ctrl_served = 0;
  logic bulk_served = 0, init_load = 0, td_done = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, init_bulk_head = 32'h0, td_addr = 32'h0, q;
  wire [31:0] avs_readdata, ctrl_next_ptr, bulk_next_ptr, ctrl_current_desc_ptr;
  wire [31:0] bulk_current_desc_ptr, link_addr, link_data, wb_data, hcca_head;
  wire avs_waitrequest, link_valid, wb_valid, irq;
  integer mismatches = 0, num_checks = 0, k, j, n;
  always #5 core_clk = ~core_clk;
  list_pointers i_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ctrl_served, .ctrl_next_ptr,
    .bulk_served, .bulk_next_ptr, .init_load, .init_bulk_head, .td_done, .td_addr,
    .ctrl_current_desc_ptr, .bulk_current_desc_ptr, .link_valid, .link_addr, .link_data,
    .wb_valid, .wb_data, .irq);
  desc_mem i_mem (.core_clk, .ctrl_current_desc_ptr, .bulk_current_desc_ptr, .ctrl_next_ptr,
    .bulk_next_ptr, .link_valid, .link_addr, .link_data, .wb_valid, .wb_data, .hcca_head);
  task summarize;
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, seen);
    end
  endtask
  // One bus cycle; waitrequest is looked at on the falling edge, clear of the launch edge
  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    @(negedge core_clk);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    q = avs_readdata;
    @(posedge core_clk);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 50) begin
      mismatches++;
      summarize();
    end
  endtask
  // One served pulse on the control (s = 0) or bulk (s = 1) list
  task serve(input integer s);
    @(posedge core_clk);
    {bulk_served, ctrl_served} <= 2'h1 << s;
    @(posedge core_clk);
    {bulk_served, ctrl_served} <= 2'h0;
  endtask
  // Returns on the falling edge after the memory has taken a writeback
  task wait_wb;
    n = 0;
    @(negedge core_clk);
    while (wb_valid !== 1'h1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 300) begin
      mismatches++;
      summarize();
    end
    @(negedge core_clk);
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    acc(1'h0, a, 32'h0);
    chk(q, e, nm);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    for (k = 0; k < 5; k++) rd(6'h20 + 4 * k, 32'h0, "reset");
    init_bulk_head <= 32'h1F;
    init_load <= 1'h1;
    @(posedge core_clk);
    init_load <= 1'h0;
    rd(6'h28, 32'h10, "bulk head");
    acc(1'h1, 6'h20, 32'h1F);
    acc(1'h1, 6'h24, 32'h1F);
    acc(1'h1, 6'h2C, 32'h1F);
    acc(1'h1, 6'h00, 32'h3);
    for (k = 0; k < 2; k++) begin
      acc(1'h1, 6'h24 + 8 * k, 32'h30);
      rd(6'h24 + 8 * k, 32'h10, "locked");
      for (j = 2; j < 5; j++) begin
        serve(k);
        rd(6'h24 + 8 * k, (j % 4) * 32'h10, "advance");
      end
      serve(k);
      rd(6'h24 + 8 * k, 32'h0, "no wrap");
      acc(1'h1, 6'h00, 32'h3 | (32'h4 << k));
      rd(6'h24 + 8 * k, 32'h0, "flag only");
      serve(k);
      rd(6'h24 + 8 * k, 32'h10, "wrap");
      rd(6'h00, 32'h3, "filled");
    end
    acc(1'h1, 6'h08, 32'h1);
    td_addr <= 32'h6F;
    td_done <= 1'h1;
    @(posedge core_clk);
    td_done <= 1'h0;
    wait_wb();
    chk(hcca_head, 32'h60, "hcca first");
    chk(irq, 32'h1, "irq");
    rd(6'h30, 32'h0, "head clear");
    acc(1'h0, 6'h04, 32'h0);
    chk(q & 32'h1, 32'h1, "status");
    @(negedge core_clk);
    chk(irq, 32'h0, "cleared");
    // A writeback just passed, so the next one is over 90 cycles away
    @(posedge core_clk);
    td_addr <= 32'h40;
    td_done <= 1'h1;
    @(posedge core_clk);
    td_addr <= 32'h50;
    @(posedge core_clk);
    td_done <= 1'h0;
    rd(6'h30, 32'h50, "done head");
    chk(i_mem.mem[5], 32'h40, "link");
    chk(i_mem.mem[4], 32'h0, "link first");
    wait_wb();
    chk(hcca_head, 32'h50, "hcca");
    chk(irq, 32'h1, "irq again");
    acc(1'h1, 6'h08, 32'h0);
    @(negedge core_clk);
    chk(irq, 32'h0, "masked");
    acc(1'h1, 6'h08, 32'h1);
    @(negedge core_clk);
    chk(irq, 32'h1, "unmasked");
    acc(1'h1, 6'h3C, 32'hFF);
    rd(6'h3C, 32'h0, "unmapped");
    summarize();
  end
endmodule // list_pointers_tb
`default_nettype wire
